// file: verilog/psr_map.svh
/*
 * psr_map.svh: offsets, field positions and reset values of the port
 * status word and the isochronous slot bitmaps.
 * Assumes byte addresses on the processor port, 32-bit words.
 */
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

// register offsets
`define PSR_OFF_PORTSC 16'h0064
`define PSR_OFF_DONE 16'h0130
`define PSR_OFF_SKIP 16'h0134
`define PSR_OFF_FINAL 16'h0138

// reset values
`define PSR_RST_PORTSC 32'h0000_2000
`define PSR_RST_DONE 32'h0000_0000
`define PSR_RST_SKIP 32'hffff_ffff
`define PSR_RST_FINAL 32'h0000_0000

// port status word field positions
`define PSR_TEST_HI 19
`define PSR_TEST_LO 16
`define PSR_IND_HI 15
`define PSR_IND_LO 14
`define PSR_HANDOFF 13
`define PSR_PWR 12
`define PSR_DP 11
`define PSR_DM 10
`define PSR_RST 8
`define PSR_SLEEP 7
`define PSR_WAKE 6
`define PSR_ON 2
`define PSR_CHG 1
`define PSR_ATT 0

`endif

// file: verilog/psr_pkg.sv
/*
 * psr_pkg: types shared by the port register block and the slot scanner.
 * Assumes nothing of its surroundings.
 */
package psr_pkg;
    typedef logic [31:0] psr_word_t;
    typedef logic [15:0] psr_addr_t;
    typedef enum logic [0:0] {
        PSR_SCAN = 1'b0,
        PSR_OFFER = 1'b1
    } psr_scan_state_t;
endpackage : psr_pkg

// file: verilog/psr_sched_if.sv
/*
 * psr_sched_if: maps and slot offer between the register block and the
 * slot scanner. Assumes both ends share ref_clk_i.
 */
`timescale 1ns/100ps
interface psr_sched_if #(parameter int SLOTS = 32, parameter int IW = 5);
    logic [SLOTS-1:0] armed;
    logic [SLOTS-1:0] skip;
    logic [SLOTS-1:0] final_map;
    logic [IW-1:0] idx;
    logic valid;
    logic take;
    modport ctl (output armed, skip, final_map, take, input idx, valid);
    modport scan (input armed, skip, final_map, take, output idx, valid);
endinterface : psr_sched_if

// file: verilog/psr_slot_scan.sv
/*
 * psr_slot_scan: walks the isochronous slots in ascending order up to the lowest
 * final slot (or slot SLOTS-1) and offers each armed, non-bypassed slot in that
 * range to the descriptor engine.
 * Assumes the engine answers an offer with take while valid is high.
 */
`timescale 1ns/100ps
module psr_slot_scan #(
    parameter int SLOTS = 32,
    parameter int IW = 5
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    psr_sched_if.scan sched
);
    import psr_pkg::*;

    psr_scan_state_t state;
    logic [IW-1:0] idx;
    logic eligible;
    logic is_last;
    logic [IW-1:0] next_idx;

    if (SLOTS < 2 || SLOTS > 32 || (1 << IW) < SLOTS) begin : g_bad_size
        $error("psr_slot_scan: SLOTS or IW out of range");
    end

    // slot eligibility and wrap point
    assign eligible = sched.armed[idx] & ~sched.skip[idx];
    assign is_last = sched.final_map[idx] || (idx == IW'(SLOTS - 1));
    assign next_idx = is_last ? '0 : idx + IW'(1);

    // scan walker, skipped slots never leave this module
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= PSR_SCAN;
            idx <= '0;
        end else begin
            case (state)
                PSR_SCAN: begin
                    if (eligible) begin
                        state <= PSR_OFFER;
                    end else begin
                        idx <= next_idx;
                    end
                end
                PSR_OFFER: begin
                    if (sched.take || !eligible) begin
                        state <= PSR_SCAN;
                        idx <= next_idx;
                    end
                end
                default: state <= PSR_SCAN;
            endcase
        end
    end

    assign sched.idx = idx;
    assign sched.valid = (state == PSR_OFFER) && eligible;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_offer_ok;
        sched.valid |-> sched.armed[idx] && !sched.skip[idx]
            && $past(sched.armed[idx] && !sched.skip[idx]);
    endproperty
    a_offer_ok: assert property (p_offer_ok)
        else $error("offered slot is not armed or is bypassed");

    property p_wrap;
        (sched.valid && sched.take && sched.final_map[idx]) |=> (idx == '0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("scan did not restart at slot zero after final slot");

    property p_ascend;
        (state == PSR_SCAN && !eligible && !is_last) |=> (idx == $past(idx) + IW'(1));
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("scan did not step to the next higher slot");
endmodule : psr_slot_scan

// file: verilog/psr_regs.sv
/*
 * psr_regs: port 1 status and control word and the isochronous completion,
 * bypass and final-slot bitmaps, with the slot scanner they steer.
 * Assumes synchronous inputs on ref_clk_i, one-cycle read and write strobes
 * from the processor port, and a descriptor engine that takes offered slots.
 *
 */
`timescale 1ns/100ps
`include "psr_map.svh"
module psr_regs #(
    parameter int SLOTS = 32,
    parameter int IW = 5
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // processor register port
    input wire psr_pkg::psr_addr_t reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire psr_pkg::psr_word_t reg_wdata_i,
    output psr_pkg::psr_word_t reg_rdata_o,
    // controller-wide configuration
    input wire logic indicator_capable_i,
    input wire logic power_switch_capable_i,
    input wire logic setup_done_i,
    // port line and state inputs
    input wire logic line_dp_i,
    input wire logic line_dm_i,
    input wire logic attach_now_i,
    input wire logic resume_seen_i,
    input wire logic port_fault_i,
    // port control outputs
    output logic [3:0] test_mode_o,
    output logic [1:0] indicator_o,
    output logic handoff_o,
    output logic port_power_o,
    output logic port_reset_o,
    output logic port_sleep_o,
    output logic port_wake_o,
    output logic port_on_o,
    // descriptor engine side
    input wire logic [SLOTS-1:0] armed_map_i,
    output logic [IW-1:0] slot_idx_o,
    output logic slot_valid_o,
    input wire logic slot_take_i,
    input wire logic slot_done_i,
    input wire logic [IW-1:0] slot_done_idx_i
);
    import psr_pkg::*;

    //**********************************************************************
    // declarations
    //**********************************************************************
    logic [3:0] test_sel;
    logic [1:0] ind;
    logic handoff;
    logic pwr;
    logic rst_flag;
    logic sleep;
    logic wake;
    logic on;
    logic chg;
    logic attach_q;
    logic setup_q;
    logic pwr_eff;
    logic wr_portsc;
    logic rd_done;
    logic [SLOTS-1:0] done_map;
    logic [SLOTS-1:0] skip_map;
    logic [SLOTS-1:0] final_map;
    logic [SLOTS-1:0] done_set;
    logic [SLOTS-1:0] done_clr;
    psr_word_t portsc_view;
    psr_word_t next_rdata;

    if (SLOTS < 2 || SLOTS > 32 || (1 << IW) < SLOTS) begin : g_bad_size
        $error("psr_regs: SLOTS or IW out of range");
    end

    //**********************************************************************
    // address decode
    //**********************************************************************
    assign wr_portsc = reg_wr_i && (reg_addr_i == `PSR_OFF_PORTSC);
    assign rd_done = reg_rd_i && (reg_addr_i == `PSR_OFF_DONE);

    // supply is always on when the port has no power switch
    assign pwr_eff = pwr | ~power_switch_capable_i;

    //**********************************************************************
    // port status and control word
    //**********************************************************************

    // test select, free to write at any time
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_sel <= 4'h0;
        end else if (wr_portsc) begin
            test_sel <= reg_wdata_i[`PSR_TEST_HI:`PSR_TEST_LO];
        end
    end

    // indicator, locked when the port has no indicator
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ind <= 2'h0;
        end else if (wr_portsc && indicator_capable_i && pwr_eff) begin
            ind <= reg_wdata_i[`PSR_IND_HI:`PSR_IND_LO];
        end
    end

    // setup done edge tracker
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            setup_q <= 1'b0;
        end else begin
            setup_q <= setup_done_i;
        end
    end

    // companion handoff: forced high, cleared on setup edge, else writable
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            handoff <= 1'b1;
        end else if (!setup_done_i) begin
            handoff <= 1'b1;
        end else if (!setup_q) begin
            handoff <= 1'b0;
        end else if (wr_portsc) begin
            handoff <= reg_wdata_i[`PSR_HANDOFF];
        end
    end

    // supply switch: writable only with a power switch, else held on
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr <= 1'b0;
        end else if (!power_switch_capable_i) begin
            pwr <= 1'b1;
        end else if (wr_portsc) begin
            pwr <= reg_wdata_i[`PSR_PWR];
        end
    end

    // bus reset, suspend and enable requests; ignored while unpowered
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_flag <= 1'b0;
            sleep <= 1'b0;
            on <= 1'b0;
        end else begin
            if (wr_portsc && pwr_eff) begin
                rst_flag <= reg_wdata_i[`PSR_RST];
                sleep <= reg_wdata_i[`PSR_SLEEP];
            end
            if (port_fault_i || !pwr_eff) begin
                on <= 1'b0; // hardware disable beats a write
            end else if (wr_portsc) begin
                on <= reg_wdata_i[`PSR_ON];
            end
        end
    end

    // resume: set by a detected K-state or by software driving it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake <= 1'b0;
        end else if (resume_seen_i && pwr_eff) begin
            wake <= 1'b1;
        end else if (wr_portsc && pwr_eff) begin
            wake <= reg_wdata_i[`PSR_WAKE];
        end
    end

    // attach change: sticky, write one to clear, a new change wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            attach_q <= 1'b0;
            chg <= 1'b0;
        end else begin
            attach_q <= attach_now_i;
            if (attach_now_i != attach_q) begin
                chg <= 1'b1;
            end else if (wr_portsc && reg_wdata_i[`PSR_CHG]) begin
                chg <= 1'b0;
            end
        end
    end

    // read view of the status word, gated while the supply is off
    always_comb begin
        portsc_view = '0;
        portsc_view[`PSR_TEST_HI:`PSR_TEST_LO] = test_sel;
        portsc_view[`PSR_HANDOFF] = handoff;
        portsc_view[`PSR_PWR] = pwr_eff;
        portsc_view[`PSR_DP] = line_dp_i;
        portsc_view[`PSR_DM] = line_dm_i;
        if (pwr_eff) begin
            portsc_view[`PSR_IND_HI:`PSR_IND_LO] = ind;
            portsc_view[`PSR_RST] = rst_flag;
            portsc_view[`PSR_SLEEP] = sleep;
            portsc_view[`PSR_WAKE] = wake;
            portsc_view[`PSR_ON] = on;
            portsc_view[`PSR_CHG] = chg;
            portsc_view[`PSR_ATT] = attach_now_i;
        end
    end

    //**********************************************************************
    // isochronous bitmaps
    //**********************************************************************

    // completion set and read-clear masks
    assign done_set = slot_done_i ? (SLOTS'(1) << slot_done_idx_i) : '0;
    assign done_clr = rd_done ? done_map : '0;

    // completion map: a completion in the read cycle survives the clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_map <= SLOTS'(`PSR_RST_DONE);
        end else begin
            done_map <= (done_map & ~done_clr) | done_set;
        end
    end

    // bypass and final-slot maps
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_map <= SLOTS'(`PSR_RST_SKIP);
            final_map <= SLOTS'(`PSR_RST_FINAL);
        end else if (reg_wr_i) begin
            if (reg_addr_i == `PSR_OFF_SKIP) begin
                skip_map <= reg_wdata_i[SLOTS-1:0];
            end else if (reg_addr_i == `PSR_OFF_FINAL) begin
                final_map <= reg_wdata_i[SLOTS-1:0];
            end
        end
    end

    //**********************************************************************
    // read data
    //**********************************************************************

    // read mux, unmapped offsets answer zero
    always_comb begin
        next_rdata = '0;
        if (reg_addr_i == `PSR_OFF_PORTSC) begin
            next_rdata = portsc_view;
        end else if (reg_addr_i == `PSR_OFF_DONE) begin
            next_rdata = psr_word_t'(done_map);
        end else if (reg_addr_i == `PSR_OFF_SKIP) begin
            next_rdata = psr_word_t'(skip_map);
        end else if (reg_addr_i == `PSR_OFF_FINAL) begin
            next_rdata = psr_word_t'(final_map);
        end
    end

    // read data held until the next read
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    //**********************************************************************
    // outputs and scanner
    //**********************************************************************
    assign test_mode_o = test_sel;
    assign indicator_o = ind;
    assign handoff_o = handoff;
    assign port_power_o = pwr;
    assign port_reset_o = rst_flag & pwr_eff;
    assign port_sleep_o = sleep & pwr_eff;
    assign port_wake_o = wake & pwr_eff;
    assign port_on_o = on;

    psr_sched_if #(.SLOTS(SLOTS), .IW(IW)) sched ();

    // the scanner sees only the maps and the take strobe, never the descriptor chain
    assign sched.armed = armed_map_i;
    assign sched.skip = skip_map;
    assign sched.final_map = final_map;
    assign sched.take = slot_take_i;
    assign slot_idx_o = sched.idx;
    assign slot_valid_o = sched.valid;

    psr_slot_scan #(.SLOTS(SLOTS), .IW(IW)) u_scan (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .sched(sched)
    );

    //**********************************************************************
    // checks
    //**********************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_test_sel;
        wr_portsc |=> (test_mode_o == $past(reg_wdata_i[`PSR_TEST_HI:`PSR_TEST_LO]));
    endproperty
    a_test_sel: assert property (p_test_sel)
        else $error("test select did not take the written value");

    property p_ind_lock;
        (wr_portsc && !indicator_capable_i) |=> $stable(indicator_o);
    endproperty
    a_ind_lock: assert property (p_ind_lock)
        else $error("indicator changed without indicator capability");

    property p_handoff_clr;
        (setup_done_i && !setup_q) |=> !handoff_o;
    endproperty
    a_handoff_clr: assert property (p_handoff_clr)
        else $error("handoff did not clear on setup done edge");

    property p_handoff_force;
        !setup_done_i |=> handoff_o;
    endproperty
    a_handoff_force: assert property (p_handoff_force)
        else $error("handoff not forced while setup done is low");

    property p_pwr_fixed;
        !power_switch_capable_i |=> port_power_o;
    endproperty
    a_pwr_fixed: assert property (p_pwr_fixed)
        else $error("supply not held on without a power switch");

    property p_wire;
        (reg_rd_i && reg_addr_i == `PSR_OFF_PORTSC)
            |=> (reg_rdata_o[`PSR_DP:`PSR_DM] == $past({line_dp_i, line_dm_i}));
    endproperty
    a_wire: assert property (p_wire)
        else $error("wire state does not match the lines");

    property p_gate;
        (reg_rd_i && reg_addr_i == `PSR_OFF_PORTSC && !pwr_eff)
            |=> (reg_rdata_o[`PSR_IND_HI:`PSR_IND_LO] == 2'h0) && (reg_rdata_o[8:0] == 9'h000);
    endproperty
    a_gate: assert property (p_gate)
        else $error("port state visible while supply is off");

    property p_chg;
        (attach_now_i != attach_q) |=> chg ##1 (chg || $past(wr_portsc));
    endproperty
    a_chg: assert property (p_chg)
        else $error("attach change not flagged");

    property p_done_set;
        slot_done_i |=> done_map[$past(slot_done_idx_i)];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("completion bit not set");

    property p_done_clr;
        (rd_done && !slot_done_i) |=> (done_map == '0) && (reg_rdata_o == psr_word_t'($past(done_map)));
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("completion map read did not return and clear");
endmodule : psr_regs

// file: testbench/psr_regs_tb_top.sv
/*
 * psr_regs_tb_top: self-checking bench for the port status word, the
 * completion, bypass and final-slot maps and the slot offers.
 * Assumes psr_regs alone, driven on ref_clk_i rising edges.
 */
`timescale 1ns/100ps
module psr_regs_tb_top;
    import psr_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    psr_addr_t reg_addr_i = '0;
    psr_word_t reg_wdata_i = '0, reg_rdata_o, armed_map_i = '0;
    logic indicator_capable_i = 1'b0, power_switch_capable_i = 1'b1, setup_done_i = 1'b0;
    logic line_dp_i = 1'b0, line_dm_i = 1'b0, attach_now_i = 1'b0, resume_seen_i = 1'b0;
    logic port_fault_i = 1'b0, slot_take_i = 1'b0, slot_done_i = 1'b0;
    logic [4:0] slot_done_idx_i = '0, slot_idx_o;
    logic [3:0] test_mode_o;
    logic [1:0] indicator_o;
    logic handoff_o, port_power_o, port_reset_o, port_sleep_o, port_wake_o, port_on_o;
    logic slot_valid_o;
    logic [15:0] seed = 16'ha640;
    int compares = 0, miscompares = 0, cycles = 0;
    psr_regs i_psr_regs (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .indicator_capable_i(indicator_capable_i),
        .power_switch_capable_i(power_switch_capable_i), .setup_done_i(setup_done_i),
        .line_dp_i(line_dp_i), .line_dm_i(line_dm_i), .attach_now_i(attach_now_i),
        .resume_seen_i(resume_seen_i), .port_fault_i(port_fault_i),
        .test_mode_o(test_mode_o), .indicator_o(indicator_o), .handoff_o(handoff_o),
        .port_power_o(port_power_o), .port_reset_o(port_reset_o),
        .port_sleep_o(port_sleep_o), .port_wake_o(port_wake_o), .port_on_o(port_on_o),
        .armed_map_i(armed_map_i), .slot_idx_o(slot_idx_o), .slot_valid_o(slot_valid_o),
        .slot_take_i(slot_take_i), .slot_done_i(slot_done_i),
        .slot_done_idx_i(slot_done_idx_i)
    );
    // 125 MHz clock and cycle ceiling
    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic psr_word_t rnd();
        for (int k = 0; k < 32; k++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            rnd[k] = seed[0];
        end
    endfunction : rnd
    // last slot of the group: lowest final bit, or 31 when none
    function automatic int grp_last(input psr_word_t f);
        for (int k = 0; k < 32; k++) begin
            if (f[k]) return k;
        end
        return 31;
    endfunction : grp_last
    // next eligible slot after cur, wrapping at the group end
    function automatic logic [4:0] nxt(input int cur, input psr_word_t el, input int last);
        int j;
        for (int k = 1; k <= 32; k++) begin
            j = (cur + k) % (last + 1);
            if (el[j]) return j[4:0];
        end
        return 5'h00;
    endfunction : nxt
    task automatic chk_word(input psr_word_t got, input psr_word_t exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_slot(input logic [4:0] got, input logic [4:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_slot
    task automatic wr(input psr_addr_t a, input psr_word_t d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input psr_addr_t a, output psr_word_t q);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge ref_clk_i);
        q = reg_rdata_o; // held until the next read
    endtask : rd
    task automatic rchk(input psr_addr_t a, input psr_word_t m, input psr_word_t exp);
        psr_word_t q;
        rd(a, q);
        chk_word(q & m, exp);
    endtask : rchk
    task automatic fin(input logic [4:0] i);
        @(posedge ref_clk_i);
        slot_done_i <= 1'b1;
        slot_done_idx_i <= i;
        @(posedge ref_clk_i);
        slot_done_i <= 1'b0;
    endtask : fin
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        psr_word_t q, ex, sk, am, el;
        psr_word_t fins [5] = '{32'h1, 32'h2, 32'h4, 32'h0000_0400, 32'h0};
        logic [3:0] t;
        int cur, last, tries;
        repeat (10) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rchk(16'h0064, '1, 32'h0000_2000);
        rchk(16'h0130, '1, 32'h0);
        rchk(16'h0134, '1, 32'hffff_ffff);
        rchk(16'h0138, '1, 32'h0);
        rchk(16'h0200, '1, 32'h0);
        // supply off: only test select, handoff and live lines show
        q = rnd();
        t = q[3:0] | 4'h1;
        line_dp_i <= 1'b1;
        wr(16'h0064, {12'h0, t, 16'hefc7});
        rchk(16'h0064, '1, {12'h0, t, 16'h2800});
        chk_word({28'h0, test_mode_o}, {28'h0, t});
        // supply on first, port state changed only once it is up
        wr(16'h0064, 32'h0000_1000);
        wr(16'h0064, 32'h0000_d184);
        rchk(16'h0064, '1, 32'h0000_3984);
        indicator_capable_i <= 1'b1;
        wr(16'h0064, 32'h0000_d184);
        rchk(16'h0064, '1, 32'h0000_f984);
        chk_word({30'h0, indicator_o}, 32'h3);
        chk_word({27'h0, port_power_o, port_reset_o, port_sleep_o, port_wake_o,
            port_on_o}, 32'h1d);
        port_fault_i <= 1'b1;
        rchk(16'h0064, '1, 32'h0000_f980);
        port_fault_i <= 1'b0;
        attach_now_i <= 1'b1;
        rchk(16'h0064, '1, 32'h0000_f983);
        wr(16'h0064, 32'h0000_d182);
        rchk(16'h0064, '1, 32'h0000_f981);
        resume_seen_i <= 1'b1;
        rchk(16'h0064, 32'h40, 32'h40);
        wr(16'h0064, 32'h0);
        rchk(16'h0064, '1, 32'h0000_2800);
        chk_word({27'h0, port_power_o, port_reset_o, port_sleep_o, port_wake_o,
            port_on_o}, 32'h0);
        power_switch_capable_i <= 1'b0;
        rchk(16'h0064, 32'h1000, 32'h1000);
        power_switch_capable_i <= 1'b1;
        // handoff follows setup done edges
        for (int k = 0; k < 3; k++) begin
            setup_done_i <= ~k[0];
            rchk(16'h0064, 32'h2000, {18'h0, k[0], 13'h0});
            chk_word({31'h0, handoff_o}, {31'h0, k[0]});
        end
        // completions, then one landing on the clearing read
        ex = '0;
        for (int k = 0; k < 12; k++) begin
            q = rnd();
            fin(q[4:0]);
            ex[q[4:0]] = 1'b1;
        end
        fork
            rd(16'h0130, q);
            fin(5'h1f);
        join
        chk_word(q, ex);
        rchk(16'h0130, '1, 32'h8000_0000);
        rchk(16'h0130, '1, 32'h0);
        // slot offers per final-slot setting
        for (int c = 0; c < 5; c++) begin
            armed_map_i <= '0;
            repeat (40) @(posedge ref_clk_i);
            sk = rnd() & ~32'h1;
            wr(16'h0134, sk);
            wr(16'h0138, fins[c]);
            rchk(16'h0134, '1, sk);
            rchk(16'h0138, '1, fins[c]);
            repeat (40) @(posedge ref_clk_i);
            am = rnd() | 32'h1;
            armed_map_i <= am;
            last = grp_last(fins[c]);
            el = am & ~sk & (32'hffff_ffff >> (31 - last));
            cur = -1;
            for (int n = 0; n < 8; n++) begin
                tries = 0;
                do begin
                    @(posedge ref_clk_i);
                    #1 tries++;
                end while (slot_valid_o !== 1'b1 && tries < 100);
                chk_word({31'h0, slot_valid_o}, 32'h1);
                if (cur < 0) begin
                    chk_word({31'h0, el[slot_idx_o]}, 32'h1);
                end else begin
                    chk_slot(slot_idx_o, nxt(cur, el, last));
                end
                cur = slot_idx_o;
                @(posedge ref_clk_i);
                slot_take_i <= 1'b1;
                @(posedge ref_clk_i);
                slot_take_i <= 1'b0;
            end
        end
        report_and_stop();
    end
endmodule : psr_regs_tb_top
